// ===== dv/tb_data_transfer_service_mapper.sv
// Self-checking testbench of the data transfer service mapper.
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
`define WAIT(s) begin n = 0; @(negedge clk); while ((s) !== 1'b1 && n < 100) begin n++; @(negedge clk); end \
    if (n == 100) miscompares++; end
module tb_data_transfer_service_mapper;
    typedef struct packed {logic dir; logic [15:0] dest; logic [7:0] tag; logic [7:0] lun; logic [31:0] buf_a;
        logic [31:0] off; logic [31:0] cnt; logic thr; logic [31:0] start; logic [31:0] thresh; logic [1:0] rc;
        logic [3:0] dly;} row_type;
    logic clk, rst_b, req_valid, req_ready, req_dir, req_throttle, tp_valid, tp_ready, tp_dir;
    logic [15:0] req_dest, tp_dest, done_dest, cnf_dest, cnf_src, fail_dest, go_dest;
    logic [7:0] req_tag, req_lun, tp_tag, done_tag, done_lun, cnf_tag, cnf_lun, fail_tag, fail_lun, go_tag, go_lun;
    logic [31:0] req_buf, req_offset, req_count, req_start, req_thresh;
    logic [31:0] tp_addr, tp_offset, tp_count, tp_start, tp_thresh;
    logic [1:0] tp_rc, rc_sel, fail_resp;
    logic [3:0] ack_delay;
    logic done_valid, done_dir, cnf_valid, cnf_kind, cnf_matched, fail_valid, fail_kind, busy_full, go, go_dir;
    row_type cur;
    row_type rows [6];
    int miscompares, num_checks;
    assign {req_dir, req_dest, req_tag, req_lun, req_buf, req_offset, req_count, req_throttle, req_start,
        req_thresh, rc_sel, ack_delay} = cur;
    xfer_map dut
    (
        .clk(clk), .rst_b(rst_b), .req_valid(req_valid), .req_ready(req_ready), .req_dir(req_dir),
        .req_dest(req_dest), .req_tag(req_tag), .req_lun(req_lun), .req_buf(req_buf), .req_offset(req_offset),
        .req_count(req_count), .req_throttle(req_throttle), .req_start(req_start), .req_thresh(req_thresh),
        .tp_valid(tp_valid), .tp_ready(tp_ready), .tp_dir(tp_dir), .tp_dest(tp_dest), .tp_tag(tp_tag),
        .tp_addr(tp_addr), .tp_offset(tp_offset), .tp_count(tp_count), .tp_start(tp_start),
        .tp_thresh(tp_thresh), .tp_rc(tp_rc), .done_valid(done_valid), .done_dir(done_dir),
        .done_dest(done_dest), .done_tag(done_tag), .done_lun(done_lun), .cnf_valid(cnf_valid),
        .cnf_kind(cnf_kind), .cnf_dest(cnf_dest), .cnf_src(cnf_src), .cnf_tag(cnf_tag), .cnf_lun(cnf_lun),
        .cnf_matched(cnf_matched), .fail_valid(fail_valid), .fail_kind(fail_kind), .fail_dest(fail_dest),
        .fail_tag(fail_tag), .fail_lun(fail_lun), .fail_resp(fail_resp), .busy_full(busy_full)
    );
    transport_model partner
    (
        .clk(clk), .rst_b(rst_b), .tp_valid(tp_valid), .tp_ready(tp_ready), .tp_rc(tp_rc), .rc_sel(rc_sel),
        .ack_delay(ack_delay), .go(go), .go_dir(go_dir), .go_dest(go_dest), .go_tag(go_tag), .go_lun(go_lun),
        .done_valid(done_valid), .done_dir(done_dir), .done_dest(done_dest), .done_tag(done_tag),
        .done_lun(done_lun)
    );
    always #5 clk = ~clk;
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic wrap_up;
        begin
            $display("checks %0d mismatches %0d", num_checks, miscompares);
            if (miscompares == 0 && num_checks > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    task automatic run_row(input row_type r);
        int n;
        begin
            @(posedge clk);
            cur <= r;
            req_valid <= 1'b1;
            `WAIT(req_ready)
            @(posedge clk);
            req_valid <= 1'b0;
            `WAIT(tp_valid)
            `CHK(tp_dir, r.dir)
            `CHK({tp_dest, tp_tag}, {r.dest, r.tag})
            `CHK({tp_addr, tp_offset, tp_count}, {r.buf_a, r.off, r.cnt})
            `CHK(tp_start, r.dir ? 32'h0 : (r.thr ? r.start : r.cnt))
            `CHK(tp_thresh, (r.thr && !r.dir) ? r.thresh : 32'h0)
            `WAIT(tp_ready)
            @(negedge clk);
            `CHK(fail_valid, r.rc != 2'h0)
            if (r.rc != 2'h0)
                `CHK({fail_kind, fail_dest, fail_tag, fail_lun, fail_resp}, {r.dir, r.dest, r.tag, r.lun, 2'h3})
        end
    endtask
    task automatic complete(input logic d, input logic [15:0] ds, input logic [7:0] tg, input logic [7:0] ln,
        input logic m);
        begin
            @(posedge clk);
            {go, go_dir, go_dest, go_tag, go_lun} <= {1'b1, d, ds, tg, ln};
            @(posedge clk);
            go <= 1'b0;
            @(posedge clk);
            @(negedge clk);
            `CHK({cnf_valid, cnf_kind, cnf_dest, cnf_tag, cnf_lun}, {1'b1, d, ds, tg, ln})
            `CHK(cnf_src, xfer_map_pkg::UNIQUE_ID_RST)
            `CHK(cnf_matched, m)
        end
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        row_type r;
        rows[0] = '{1'b0, 16'h0101, 8'h11, 8'h01, 32'h1000, 32'h0, 32'h200, 1'b0, 32'h5, 32'h6, 2'h0, 4'h0};
        rows[1] = '{1'b0, 16'h0202, 8'h22, 8'h02, 32'h2000, 32'h10, 32'h400, 1'b1, 32'h100, 32'h80, 2'h0, 4'h3};
        rows[2] = '{1'b1, 16'h0303, 8'h33, 8'h03, 32'h3000, 32'h20, 32'h80, 1'b1, 32'h9, 32'h9, 2'h0, 4'h7};
        rows[3] = '{1'b0, 16'hFFFF, 8'hFF, 8'h04, 32'hFFFFFFFF, 32'h1, 32'h1, 1'b0, 32'h0, 32'h0, 2'h1, 4'h0};
        rows[4] = '{1'b1, 16'h0505, 8'h55, 8'h05, 32'h5000, 32'h0, 32'h0, 1'b0, 32'h0, 32'h0, 2'h1, 4'h2};
        rows[5] = '{1'b1, 16'h0606, 8'h66, 8'h06, 32'h6000, 32'h4, 32'h8, 1'b0, 32'h0, 32'h0, 2'h2, 4'h1};
        clk = 1'b0;
        rst_b = 1'b0;
        req_valid = 1'b0;
        cur = '0;
        {go, go_dir, go_dest, go_tag, go_lun} = '0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        `CHK({req_ready, tp_valid, cnf_valid, fail_valid, busy_full}, 5'h10)
        $display("test reset done");
        for (int i = 0; i < 6; i++)
        begin
            run_row(rows[i]);
            $display("test row %0d done", i);
        end
        // Completions arrive out of issue order to exercise the lookup.
        complete(1'b1, rows[2].dest, rows[2].tag, rows[2].lun, 1'b1);
        complete(1'b0, rows[1].dest, rows[1].tag, rows[1].lun, 1'b1);
        complete(1'b0, rows[0].dest, rows[0].tag, rows[0].lun, 1'b1);
        complete(1'b0, rows[3].dest, rows[3].tag, rows[3].lun, 1'b0);
        $display("test completions done");
        r = rows[0];
        for (int i = 0; i < 4; i++)
        begin
            r.tag = 8'h40 + 8'(i);
            run_row(r);
        end
        `CHK({busy_full, req_ready}, 2'h2)
        // A request held while the table is full must not stop a completion from freeing its slot.
        r.tag = 8'h44;
        @(posedge clk);
        cur <= r;
        req_valid <= 1'b1;
        complete(1'b0, r.dest, 8'h40, r.lun, 1'b1);
        `CHK(req_ready, 1'b1)
        @(posedge clk);
        req_valid <= 1'b0;
        @(negedge clk);
        `CHK({tp_valid, tp_tag}, {1'b1, 8'h44})
        for (int i = 1; i < 5; i++)
            complete(1'b0, r.dest, 8'h40 + 8'(i), r.lun, 1'b1);
        `CHK({busy_full, req_ready}, 2'h1)
        $display("test full table done");
        // A reset in mid-run drops every outstanding entry.
        run_row(rows[1]);
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        `CHK({req_ready, tp_valid, cnf_valid, fail_valid, busy_full}, 5'h10)
        complete(1'b0, rows[1].dest, rows[1].tag, rows[1].lun, 1'b0);
        $display("test mid-run reset done");
        wrap_up;
    end
    initial
    begin
        #50000;
        miscompares++;
        wrap_up;
    end
endmodule

// ===== dv/transport_model.sv
// Behavioural transport engine that answers the mapper's invocations.
`timescale 1ns/10ps
module transport_model
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic tp_valid,
    output logic tp_ready,
    output logic [1:0] tp_rc,
    input wire logic [1:0] rc_sel,
    input wire logic [3:0] ack_delay,
    input wire logic go,
    input wire logic go_dir,
    input wire logic [15:0] go_dest,
    input wire logic [7:0] go_tag,
    input wire logic [7:0] go_lun,
    output logic done_valid,
    output logic done_dir,
    output logic [15:0] done_dest,
    output logic [7:0] done_tag,
    output logic [7:0] done_lun
);
    logic [3:0] wait_cnt;
    // The return code is only meaningful in the accept cycle; outside it the lines toggle.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            {tp_ready, tp_rc, wait_cnt} <= '0;
            {done_valid, done_dir, done_dest, done_tag, done_lun} <= '0;
        end
        else
        begin
            tp_ready <= 1'b0;
            tp_rc <= ~tp_rc;
            if (tp_valid && !tp_ready)
            begin
                wait_cnt <= (wait_cnt == ack_delay) ? 4'h0 : wait_cnt + 4'h1;
                if (wait_cnt == ack_delay)
                begin
                    tp_ready <= 1'b1;
                    tp_rc <= rc_sel;
                end
            end
            // A completion stands for the transfer's data phase having run to its end.
            done_valid <= go;
            done_dir <= go ? go_dir : ~done_dir;
            done_dest <= go ? go_dest : ~done_dest;
            done_tag <= go ? go_tag : ~done_tag;
            done_lun <= go ? go_lun : ~done_lun;
        end
    end
endmodule

// ===== pkg/xfer_map_pkg.sv
// Package of widths, codes and constants for the data transfer service mapper.
package xfer_map_pkg;
    localparam int ID_W = 16;
    localparam int TAG_W = 8;
    localparam int LUN_W = 8;
    localparam int ADDR_W = 32;
    localparam int CNT_W = 32;
    localparam int SLOTS = 4;
    localparam int SLOT_W = 2;
    // Transport return codes.
    localparam logic [1:0] RC_SUCCESS = 2'h0;
    localparam logic [1:0] RC_FAILED = 2'h1;
    localparam logic [1:0] RC_INVALID = 2'h2;
    // Service response code reported upward on failure.
    localparam logic [1:0] SR_TASK_COMPLETE = 2'h0;
    localparam logic [1:0] SR_DELIVERY_FAIL = 2'h3;
    // Threshold count used for normal, unthrottled reads.
    localparam logic [31:0] THRESH_NORMAL = 32'h0;
    // Source identifier of this target; value is arbitrary.
    localparam logic [15:0] UNIQUE_ID_RST = 16'h00A5;
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_ISSUE = 2'b01,
        ST_WAIT = 2'b11
    } issue_state_type;
endpackage

// ===== src/xfer_map.sv
// Target-side mapper between data transfer requests and transport read/write services.
`timescale 1ns/10ps
module xfer_map
(
    input wire logic clk,
    input wire logic rst_b,
    // Upper-layer request: dir 0 is Data-In, 1 is Data-Out.
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_dir,
    input wire logic [15:0] req_dest,
    input wire logic [7:0] req_tag,
    input wire logic [7:0] req_lun,
    input wire logic [31:0] req_buf,
    input wire logic [31:0] req_offset,
    input wire logic [31:0] req_count,
    input wire logic req_throttle,
    input wire logic [31:0] req_start,
    input wire logic [31:0] req_thresh,
    // Transport invocation: dir 0 target read, 1 target write.
    output logic tp_valid,
    input wire logic tp_ready,
    output logic tp_dir,
    output logic [15:0] tp_dest,
    output logic [7:0] tp_tag,
    output logic [31:0] tp_addr,
    output logic [31:0] tp_offset,
    output logic [31:0] tp_count,
    output logic [31:0] tp_start,
    output logic [31:0] tp_thresh,
    input wire logic [1:0] tp_rc,
    // Transport completion indication: dir 0 read done, 1 write done.
    input wire logic done_valid,
    input wire logic done_dir,
    input wire logic [15:0] done_dest,
    input wire logic [7:0] done_tag,
    input wire logic [7:0] done_lun,
    // Confirmation: kind 0 Data-Sent, 1 Data-Out-Received.
    output logic cnf_valid,
    output logic cnf_kind,
    output logic [15:0] cnf_dest,
    output logic [15:0] cnf_src,
    output logic [7:0] cnf_tag,
    output logic [7:0] cnf_lun,
    output logic cnf_matched,
    // Failure completion: kind 0 completion to upper layer, 1 command-complete request.
    output logic fail_valid,
    output logic fail_kind,
    output logic [15:0] fail_dest,
    output logic [7:0] fail_tag,
    output logic [7:0] fail_lun,
    output logic [1:0] fail_resp,
    output logic busy_full
);
    // ------------------------------------------------------------
    // Outstanding transfer table
    // ------------------------------------------------------------
    logic [xfer_map_pkg::SLOTS-1:0] vld_ff, nxt_vld;
    logic [7:0] tag_ff [xfer_map_pkg::SLOTS];
    logic [7:0] lun_ff [xfer_map_pkg::SLOTS];
    logic [15:0] dst_ff [xfer_map_pkg::SLOTS];
    logic [xfer_map_pkg::SLOTS-1:0] hit;
    logic [xfer_map_pkg::SLOT_W-1:0] free_idx, hit_idx, slot_ff, nxt_slot;
    logic free_any, hit_any;
    xfer_map_pkg::issue_state_type state_ff, nxt_state;
    function automatic logic [2:0] first_one(input logic [3:0] v);
        logic [2:0] r;
        r = 3'h4;
        for (int i = 3; i >= 0; i--)
        begin
            if (v[i])
            begin
                r = 3'(i);
            end
        end
        return r;
    endfunction
    genvar g;
    generate
        for (g = 0; g < xfer_map_pkg::SLOTS; g++)
        begin : g_hit
            assign hit[g] = vld_ff[g] && tag_ff[g] == done_tag && lun_ff[g] == done_lun
                && dst_ff[g] == done_dest;
        end
    endgenerate
    always_comb
    begin
        logic [2:0] f;
        logic [2:0] h;
        f = first_one(~vld_ff);
        h = first_one(hit);
        free_any = !f[2];
        hit_any = !h[2];
        free_idx = f[1:0];
        hit_idx = h[1:0];
    end
    assign busy_full = !free_any;

    // ------------------------------------------------------------
    // Request sequencer
    // ------------------------------------------------------------
    logic [1:0] rc_q;
    logic inv_done;
    assign req_ready = (state_ff == xfer_map_pkg::ST_IDLE) && free_any;
    assign tp_valid = (state_ff == xfer_map_pkg::ST_ISSUE);
    assign inv_done = tp_valid && tp_ready;
    assign rc_q = tp_rc;
    always_comb
    begin
        nxt_state = state_ff;
        nxt_slot = slot_ff;
        nxt_vld = vld_ff;
        case (state_ff)
            xfer_map_pkg::ST_IDLE:
            begin
                if (req_valid && free_any)
                begin
                    nxt_state = xfer_map_pkg::ST_ISSUE;
                    nxt_slot = free_idx;
                    nxt_vld[free_idx] = 1'b1;
                end
            end
            xfer_map_pkg::ST_ISSUE:
            begin
                if (inv_done)
                begin
                    nxt_state = xfer_map_pkg::ST_IDLE;
                    if (rc_q != xfer_map_pkg::RC_SUCCESS)
                    begin
                        nxt_vld[slot_ff] = 1'b0;
                    end
                end
            end
            default:
            begin
                nxt_state = xfer_map_pkg::ST_IDLE;
            end
        endcase
        // A request waiting on a full table must not hold back a completion, so only a real claim wins.
        if (done_valid && hit_any
            && !(state_ff == xfer_map_pkg::ST_IDLE && req_valid && free_any && free_idx == hit_idx))
        begin
            nxt_vld[hit_idx] = 1'b0;
        end
    end
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_ff <= xfer_map_pkg::ST_IDLE;
            slot_ff <= '0;
            vld_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            slot_ff <= nxt_slot;
            vld_ff <= nxt_vld;
        end
    end
    // ------------------------------------------------------------
    // Invocation parameters and table fields
    // ------------------------------------------------------------
    logic nxt_dir;
    logic [15:0] nxt_dest;
    logic [7:0] nxt_tag, nxt_lun, lun_q_ff;
    logic [31:0] nxt_addr, nxt_off, nxt_cnt, nxt_start, nxt_thresh;
    logic load;
    assign load = state_ff == xfer_map_pkg::ST_IDLE && req_valid && free_any;
    always_comb
    begin
        {nxt_dir, nxt_dest, nxt_tag, nxt_lun, nxt_addr, nxt_off, nxt_cnt, nxt_start, nxt_thresh} =
            {tp_dir, tp_dest, tp_tag, lun_q_ff, tp_addr, tp_offset, tp_count, tp_start, tp_thresh};
        if (load)
        begin
            nxt_dir = req_dir;
            nxt_lun = req_lun;
            {nxt_dest, nxt_tag} = {req_dest, req_tag};
            {nxt_addr, nxt_off, nxt_cnt} = {req_buf, req_offset, req_count};
            // Writes carry no throttle values; zero keeps the lines quiet.
            nxt_start = req_dir ? '0 : (req_throttle ? req_start : req_count);
            nxt_thresh = req_dir ? '0 : (req_throttle ? req_thresh : xfer_map_pkg::THRESH_NORMAL);
        end
    end
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            {tp_dir, tp_dest, tp_tag, lun_q_ff, tp_addr, tp_offset, tp_count, tp_start, tp_thresh} <= '0;
        end
        else
        begin
            {tp_dir, tp_dest, tp_tag, lun_q_ff, tp_addr, tp_offset, tp_count, tp_start, tp_thresh} <=
                {nxt_dir, nxt_dest, nxt_tag, nxt_lun, nxt_addr, nxt_off, nxt_cnt, nxt_start, nxt_thresh};
        end
    end
    always_ff @(posedge clk)
    begin
        if (load)
        begin
            tag_ff[free_idx] <= req_tag;
            lun_ff[free_idx] <= req_lun;
            dst_ff[free_idx] <= req_dest;
        end
    end
    // ------------------------------------------------------------
    // Confirmations and failure reports
    // ------------------------------------------------------------
    logic nxt_cnf_v, nxt_fail_v, fail_now;
    assign fail_now = inv_done && rc_q != xfer_map_pkg::RC_SUCCESS;
    assign nxt_cnf_v = done_valid;
    assign nxt_fail_v = fail_now;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            {cnf_valid, cnf_kind, cnf_dest, cnf_src, cnf_tag, cnf_lun, cnf_matched} <= '0;
            {fail_valid, fail_kind, fail_dest, fail_tag, fail_lun} <= '0;
            fail_resp <= xfer_map_pkg::SR_TASK_COMPLETE;
        end
        else
        begin
            cnf_valid <= nxt_cnf_v;
            fail_valid <= nxt_fail_v;
            if (done_valid)
            begin
                cnf_kind <= done_dir;
                cnf_dest <= done_dest;
                cnf_src <= xfer_map_pkg::UNIQUE_ID_RST;
                cnf_tag <= done_tag;
                cnf_lun <= done_lun;
                cnf_matched <= hit_any;
            end
            if (fail_now)
            begin
                fail_kind <= tp_dir;
                fail_dest <= tp_dest;
                fail_tag <= tp_tag;
                fail_lun <= lun_q_ff;
                fail_resp <= xfer_map_pkg::SR_DELIVERY_FAIL;
            end
        end
    end
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_read_fwd: assert property (@(posedge clk) disable iff (!rst_b)
        load && !req_dir |=> tp_valid && tp_dest == $past(req_dest) && tp_tag == $past(req_tag))
        else $error("read request not forwarded");
    a_read_params: assert property (@(posedge clk) disable iff (!rst_b)
        load |=> tp_addr == $past(req_buf) && tp_offset == $past(req_offset) && tp_count == $past(req_count))
        else $error("transfer parameters wrong");
    a_throttle_use: assert property (@(posedge clk) disable iff (!rst_b)
        load && !req_dir && req_throttle |=> tp_start == $past(req_start) && tp_thresh == $past(req_thresh))
        else $error("throttle values not passed");
    a_normal_start: assert property (@(posedge clk) disable iff (!rst_b)
        load && !req_dir && !req_throttle |=> tp_start == tp_count && tp_thresh == 32'h0)
        else $error("default start or threshold wrong");
    a_read_fail: assert property (@(posedge clk) disable iff (!rst_b)
        fail_now && !tp_dir |=> fail_valid && !fail_kind && fail_resp == xfer_map_pkg::SR_DELIVERY_FAIL)
        else $error("read failure not reported");
    a_write_fail: assert property (@(posedge clk) disable iff (!rst_b)
        fail_now && tp_dir |=> fail_valid && fail_kind && fail_tag == $past(tp_tag))
        else $error("write failure not reported");
    a_sent_cnf: assert property (@(posedge clk) disable iff (!rst_b)
        done_valid && !done_dir |=> cnf_valid && !cnf_kind && cnf_tag == $past(done_tag)
        && cnf_src == xfer_map_pkg::UNIQUE_ID_RST)
        else $error("data sent confirmation wrong");
    a_recv_cnf: assert property (@(posedge clk) disable iff (!rst_b)
        done_valid && done_dir |=> cnf_valid && cnf_kind && cnf_lun == $past(done_lun)
        && cnf_dest == $past(done_dest))
        else $error("data out received confirmation wrong");
    a_write_fwd: assert property (@(posedge clk) disable iff (!rst_b)
        load && req_dir |=> tp_valid && tp_dir && tp_tag == $past(req_tag))
        else $error("write request not forwarded");
    a_slot_kept: assert property (@(posedge clk) disable iff (!rst_b)
        inv_done && rc_q == xfer_map_pkg::RC_SUCCESS |=> vld_ff[$past(slot_ff)] || $past(done_valid))
        else $error("outstanding slot lost");
    c_read_ok: cover property (@(posedge clk) disable iff (!rst_b) inv_done && !tp_dir ##[1:20] cnf_valid && !cnf_kind);
    c_write_ok: cover property (@(posedge clk) disable iff (!rst_b) inv_done && tp_dir ##[1:20] cnf_valid && cnf_kind);
    c_fail: cover property (@(posedge clk) disable iff (!rst_b) fail_valid);
    c_full: cover property (@(posedge clk) disable iff (!rst_b) busy_full);
endmodule
